// ---- src/pmra_pkg.sv ----
// package: constants, types and register map of the power-mode and register block
// assumes a 20 MHz core clock and an 8-bit register port from the host interface logic
package pmra_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SPIKE_NS = 10;
	localparam int RST_MIN_NS = 100;
	// longest spike that must be rejected, rounded down, at least one cycle
	localparam int SPIKE_CYC = (SPIKE_NS / CLK_PERIOD_NS) < 1 ? 1 : SPIKE_NS / CLK_PERIOD_NS;
	localparam int RST_FILT_CYC = RST_MIN_NS / CLK_PERIOD_NS;
	localparam int STARTUP_CLKS = 1024;
	localparam int WAKE_CLKS = 1024;
	// fifo
	localparam int FIFO_DEPTH = 64;
	localparam int FIFO_W = 8;
	// register addresses
	localparam int ADDR_W = 6;
	localparam logic [5:0] A_RSVD0 = 6'h00;
	localparam logic [5:0] A_CMD = 6'h01;
	localparam logic [5:0] A_COMM_EN = 6'h02;
	localparam logic [5:0] A_MISC_EN = 6'h03;
	localparam logic [5:0] A_COMM_IRQ = 6'h04;
	localparam logic [5:0] A_MISC_IRQ = 6'h05;
	localparam logic [5:0] A_ERROR = 6'h06;
	localparam logic [5:0] A_STAT1 = 6'h07;
	localparam logic [5:0] A_STAT2 = 6'h08;
	localparam logic [5:0] A_FIFO_DATA = 6'h09;
	localparam logic [5:0] A_FIFO_LVL = 6'h0a;
	localparam logic [5:0] A_WATER = 6'h0b;
	localparam logic [5:0] A_MISC_CTL = 6'h0c;
	localparam logic [5:0] A_TX_CTL = 6'h14;
	// field positions
	localparam int CMD_SLEEP_BIT = 4;
	localparam int IRQ_SET_BIT = 7;
	localparam int LVL_FLUSH_BIT = 7;
	localparam int CTL_START_BIT = 6;
	localparam int CTL_STOP_BIT = 7;
	localparam int TX_EN1_BIT = 0;
	localparam int TX_EN2_BIT = 1;
	localparam logic [3:0] CMD_IDLE = 4'h0;
	// reset values
	localparam logic [7:0] RST_IRQ_EN = 8'h00;
	localparam logic [6:0] RST_IRQ_REQ = 7'h00;
	localparam logic [5:0] RST_WATER = 6'h08;
	localparam logic [3:0] RST_STAT2_CTL = 4'h0;
	localparam logic [7:0] RST_TX_CTL = 8'h00;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} pmra_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} pmra_rsp_t;

	typedef enum logic [3:0] {
		ST_START = 4'b0001,
		ST_RUN = 4'b0010,
		ST_SLEEP = 4'b0100,
		ST_WAKE = 4'b1000
	} pmra_state_t;
endpackage : pmra_pkg

// ---- src/pmra_pin_filter.sv ----
// reset/power-down pin synchroniser and spike filter
// assumes the pin is asynchronous to clk_i; output is a registered level
`timescale 1ns/1ns
module pmra_pin_filter #(
	parameter int FILT_CYC = pmra_pkg::RST_FILT_CYC
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic pin_n_i,
	output logic hard_pd_o
);
	import pmra_pkg::*;

	if (FILT_CYC < 2 || FILT_CYC > 15 || FILT_CYC <= SPIKE_CYC) begin : g_chk
		$error("pmra_pin_filter: FILT_CYC out of range");
	end

	logic sync1_r;
	logic sync2_r;
	logic [3:0] low_cnt_r;
	logic [3:0] low_cnt_nxt;
	logic hard_pd_r;

	// saturating count of consecutive low samples
	assign low_cnt_nxt = sync2_r ? 4'h0 :
		(low_cnt_r == 4'(FILT_CYC)) ? low_cnt_r : low_cnt_r + 4'h1;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			low_cnt_r <= 4'h0;
			hard_pd_r <= 1'b0;
		end else begin
			sync1_r <= pin_n_i;
			sync2_r <= sync1_r;
			low_cnt_r <= low_cnt_nxt;
			hard_pd_r <= (low_cnt_nxt == 4'(FILT_CYC));
		end
	end

	assign hard_pd_o = hard_pd_r;
endmodule : pmra_pin_filter

// ---- src/pmra_fifo_mem.sv ----
// single-port-write, single-port-read byte store for the host fifo
// assumes pointer logic outside; read data appear one cycle after rd_en
`timescale 1ns/1ns
module pmra_fifo_mem #(
	parameter int W = pmra_pkg::FIFO_W,
	parameter int DEPTH = pmra_pkg::FIFO_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [W-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [W-1:0] rd_data_o
);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("pmra_fifo_mem: DEPTH must be a power of two");
	end

	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] rd_data_r;

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
		if (rd_en_i) begin
			rd_data_r <= mem_r[rd_addr_i];
		end
	end

	assign rd_data_o = rd_data_r;
endmodule : pmra_fifo_mem

// ---- src/pmra_top.sv ----
// power-mode sequencing and page-0 register file of the reader controller
// assumes host register port on clk_i (requests one cycle wide), reset pin asynchronous
`timescale 1ns/1ns
module pmra_top #(
	parameter int STARTUP_CYC = pmra_pkg::STARTUP_CLKS,
	parameter int WAKE_CYC = pmra_pkg::WAKE_CLKS,
	parameter int DEPTH = pmra_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reset_soft_sleep_bit_pin_n_i,
	input wire pmra_pkg::pmra_req_t host_req_i,
	output pmra_pkg::pmra_rsp_t host_rsp_o,
	output logic host_ready_o,
	output logic osc_en_o,
	output logic osc_buf_en_o,
	output logic antenna1_drive_o,
	output logic antenna2_drive_o,
	output logic [3:0] cmd_code_o,
	output logic timer_start_o,
	output logic timer_stop_o,
	input wire logic cmd_done_i,
	input wire logic [6:0] comm_irq_event_i,
	input wire logic [6:0] misc_irq_event_i,
	input wire logic [7:0] error_flags_i,
	input wire logic [5:0] status1_i,
	input wire logic [3:0] status2_i,
	input wire logic [5:0] misc_status_i
);
	import pmra_pkg::*;

	localparam int CW = $clog2((STARTUP_CYC > WAKE_CYC ? STARTUP_CYC : WAKE_CYC) + 1);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = AW + 1;

	if (STARTUP_CYC < 1 || WAKE_CYC < 1 || DEPTH < 2 || DEPTH > 127) begin : g_chk
		$error("pmra_top: parameter out of range");
	end

	// address match used by both the write and the read path
	function automatic logic hit(input logic [5:0] a, input logic [5:0] ref_a);
		hit = (a == ref_a);
	endfunction : hit

	// pin filter and core reset
	logic hard_pd;
	logic core_rst;

	pmra_pin_filter #(
		.FILT_CYC(RST_FILT_CYC)
	) u_pin_filter (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.pin_n_i(reset_soft_sleep_bit_pin_n_i),
		.hard_pd_o(hard_pd)
	);

	// hard power-down acts as a reset of all core state
	assign core_rst = reset_i | hard_pd;

	// sequencing state
	pmra_state_t state_r;
	pmra_state_t state_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic osc_en_r;
	logic osc_buf_en_r;
	logic ready_r;

	// request qualification: nothing is taken while isolated or starting
	logic acc_ok;
	logic do_wr;
	logic do_rd;
	logic [5:0] a;
	logic [7:0] wd;

	assign acc_ok = ~hard_pd & ready_r;
	assign do_wr = acc_ok & host_req_i.wr;
	assign do_rd = acc_ok & host_req_i.rd & ~host_req_i.wr;
	assign a = host_req_i.addr;
	assign wd = host_req_i.wdata;

	logic wr_cmd;
	logic wr_comm_en;
	logic wr_misc_en;
	logic wr_comm_irq;
	logic wr_misc_irq;
	logic wr_stat2;
	logic wr_fifo;
	logic wr_lvl;
	logic wr_water;
	logic wr_ctl;
	logic wr_tx;
	logic rd_fifo;

	assign wr_cmd = do_wr & hit(a, A_CMD);
	assign wr_comm_en = do_wr & hit(a, A_COMM_EN);
	assign wr_misc_en = do_wr & hit(a, A_MISC_EN);
	assign wr_comm_irq = do_wr & hit(a, A_COMM_IRQ);
	assign wr_misc_irq = do_wr & hit(a, A_MISC_IRQ);
	assign wr_stat2 = do_wr & hit(a, A_STAT2);
	assign wr_fifo = do_wr & hit(a, A_FIFO_DATA);
	assign wr_lvl = do_wr & hit(a, A_FIFO_LVL);
	assign wr_water = do_wr & hit(a, A_WATER);
	assign wr_ctl = do_wr & hit(a, A_MISC_CTL);
	assign wr_tx = do_wr & hit(a, A_TX_CTL);
	assign rd_fifo = do_rd & hit(a, A_FIFO_DATA);

	// sleep bit write decode
	logic sleep_set;
	logic sleep_clr;
	logic in_sleep;
	logic cnt_done;

	assign sleep_set = wr_cmd & wd[CMD_SLEEP_BIT];
	assign sleep_clr = wr_cmd & ~wd[CMD_SLEEP_BIT];
	assign in_sleep = (state_r == ST_SLEEP) | (state_r == ST_WAKE);
	assign cnt_done = (state_r == ST_START) ? (cnt_r == CW'(STARTUP_CYC - 1)) :
		(cnt_r == CW'(WAKE_CYC - 1));

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			ST_START: begin
				cnt_nxt = cnt_r + CW'(1);
				if (cnt_done) begin
					state_nxt = ST_RUN;
					cnt_nxt = '0;
				end
			end
			ST_RUN: begin
				if (sleep_set) begin
					state_nxt = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				cnt_nxt = '0;
				if (sleep_clr) begin
					state_nxt = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (sleep_set) begin
					state_nxt = ST_SLEEP;
					cnt_nxt = '0;
				end else if (osc_buf_en_r) begin
					cnt_nxt = cnt_r + CW'(1);
					if (cnt_done) begin
						state_nxt = ST_RUN;
						cnt_nxt = '0;
					end
				end
			end
			default: begin
				state_nxt = ST_START;
				cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			state_r <= ST_START;
			cnt_r <= '0;
			ready_r <= 1'b0;
			osc_buf_en_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			ready_r <= (state_nxt != ST_START);
			osc_buf_en_r <= (state_nxt != ST_SLEEP);
		end
	end

	// oscillator stays off for as long as the pin holds the part down
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			osc_en_r <= 1'b0;
		end else begin
			osc_en_r <= 1'b1;
		end
	end

	// control registers, only the host changes them, except cmd_r, which completion returns to idle
	logic [7:0] comm_en_r;
	logic [7:0] misc_en_r;
	logic [5:0] water_r;
	logic [3:0] stat2_ctl_r;
	logic [7:0] tx_ctl_r;
	logic [3:0] cmd_r;

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			comm_en_r <= RST_IRQ_EN;
			misc_en_r <= RST_IRQ_EN;
			water_r <= RST_WATER;
			stat2_ctl_r <= RST_STAT2_CTL;
			tx_ctl_r <= RST_TX_CTL;
		end else begin
			if (wr_comm_en) begin
				comm_en_r <= wd;
			end
			if (wr_misc_en) begin
				misc_en_r <= wd;
			end
			if (wr_water) begin
				water_r <= wd[5:0];
			end
			if (wr_stat2) begin
				stat2_ctl_r <= wd[7:4];
			end
			if (wr_tx) begin
				tx_ctl_r <= wd;
			end
		end
	end

	// command field: host writes, completion returns it to idle
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			cmd_r <= CMD_IDLE;
		end else if (wr_cmd) begin
			cmd_r <= wd[3:0];
		end else if (cmd_done_i) begin
			cmd_r <= CMD_IDLE;
		end
	end

	// interrupt request bits: bit 7 of a write selects set or clear, events win
	logic [6:0] comm_irq_r;
	logic [6:0] misc_irq_r;
	logic [6:0] comm_irq_nxt;
	logic [6:0] misc_irq_nxt;

	for (genvar i = 0; i < 7; i++) begin : g_irq
		assign comm_irq_nxt[i] = comm_irq_event_i[i] |
			(wr_comm_irq ? (wd[IRQ_SET_BIT] ? (comm_irq_r[i] | wd[i]) :
			(comm_irq_r[i] & ~wd[i])) : comm_irq_r[i]);
		assign misc_irq_nxt[i] = misc_irq_event_i[i] |
			(wr_misc_irq ? (wd[IRQ_SET_BIT] ? (misc_irq_r[i] | wd[i]) :
			(misc_irq_r[i] & ~wd[i])) : misc_irq_r[i]);
	end

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			comm_irq_r <= RST_IRQ_REQ;
			misc_irq_r <= RST_IRQ_REQ;
		end else begin
			comm_irq_r <= comm_irq_nxt;
			misc_irq_r <= misc_irq_nxt;
		end
	end

	// fifo pointers and level; sleep leaves them untouched
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [LW-1:0] level_r;
	logic flush;
	logic push;
	logic pop;
	logic [7:0] fifo_rdata;

	assign flush = wr_lvl & wd[LVL_FLUSH_BIT];
	assign push = wr_fifo & (level_r != LW'(DEPTH));
	assign pop = rd_fifo & (level_r != '0);

	always_ff @(posedge clk_i) begin
		if (core_rst || flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			level_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + AW'(1);
			end
			if (push && !pop) begin
				level_r <= level_r + LW'(1);
			end else if (pop && !push) begin
				level_r <= level_r - LW'(1);
			end
		end
	end

	pmra_fifo_mem #(
		.W(FIFO_W),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo_mem (
		.clk_i(clk_i),
		.wr_en_i(push),
		.wr_addr_i(wr_ptr_r),
		.wr_data_i(wd),
		.rd_en_i(pop),
		.rd_addr_i(rd_ptr_r),
		.rd_data_o(fifo_rdata)
	);

	// fill alerts against the threshold
	logic hi_alert;
	logic lo_alert;

	assign hi_alert = ((LW'(DEPTH) - level_r) <= LW'(water_r));
	assign lo_alert = (level_r <= LW'(water_r));

	// read pipeline: address held one cycle so fifo data can arrive
	logic rd_pend_r;
	logic [5:0] rd_addr_r;
	logic [7:0] rd_mux;

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			rd_pend_r <= 1'b0;
			rd_addr_r <= A_RSVD0;
		end else begin
			rd_pend_r <= do_rd;
			rd_addr_r <= a;
		end
	end

	// write-only and reserved bits read as zero, read-only bits from state
	always_comb begin
		case (rd_addr_r)
			A_CMD: rd_mux = {3'b000, in_sleep, cmd_r};
			A_COMM_EN: rd_mux = comm_en_r;
			A_MISC_EN: rd_mux = misc_en_r;
			A_COMM_IRQ: rd_mux = {1'b0, comm_irq_r};
			A_MISC_IRQ: rd_mux = {1'b0, misc_irq_r};
			A_ERROR: rd_mux = error_flags_i;
			A_STAT1: rd_mux = {status1_i, hi_alert, lo_alert};
			A_STAT2: rd_mux = {stat2_ctl_r, status2_i};
			A_FIFO_DATA: rd_mux = fifo_rdata;
			A_FIFO_LVL: rd_mux = {{(8 - LW){1'b0}}, level_r};
			A_WATER: rd_mux = {2'b00, water_r};
			A_MISC_CTL: rd_mux = {2'b00, misc_status_i};
			A_TX_CTL: rd_mux = tx_ctl_r;
			default: rd_mux = 8'h00;
		endcase
	end

	// host response, ready and antenna outputs hold their level while the part is held down
	pmra_rsp_t rsp_r;
	logic host_ready_r;
	logic ant1_r;
	logic ant2_r;
	logic rf_on;

	// field only with both drivers enabled and the core awake
	assign rf_on = tx_ctl_r[TX_EN1_BIT] & tx_ctl_r[TX_EN2_BIT] & ~in_sleep;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rsp_r <= '0;
			host_ready_r <= 1'b0;
			ant1_r <= 1'b0;
			ant2_r <= 1'b0;
		end else if (!hard_pd) begin
			rsp_r.valid <= rd_pend_r;
			rsp_r.data <= rd_pend_r ? rd_mux : rsp_r.data;
			host_ready_r <= ready_r;
			ant1_r <= rf_on;
			ant2_r <= rf_on;
		end
	end

	// timer strobes from write-only control bits
	logic tstart_r;
	logic tstop_r;

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			tstart_r <= 1'b0;
			tstop_r <= 1'b0;
		end else begin
			tstart_r <= wr_ctl & wd[CTL_START_BIT];
			tstop_r <= wr_ctl & wd[CTL_STOP_BIT];
		end
	end

	logic [3:0] cmd_out_r;

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			cmd_out_r <= CMD_IDLE;
		end else begin
			cmd_out_r <= cmd_r;
		end
	end

	assign host_rsp_o = rsp_r;
	assign host_ready_o = host_ready_r;
	assign osc_en_o = osc_en_r;
	assign osc_buf_en_o = osc_buf_en_r;
	assign antenna1_drive_o = ant1_r;
	assign antenna2_drive_o = ant2_r;
	assign cmd_code_o = cmd_out_r;
	assign timer_start_o = tstart_r;
	assign timer_stop_o = tstop_r;
endmodule : pmra_top

// ---- test/pmra_top_monitor.sv ----
// checker of the power-mode block, bound to its top module
// sees top ports only; start-up and wake counts set to 8
`timescale 1ns/1ns
module pmra_top_monitor #(
	parameter int STARTUP_CYC = 8,
	parameter int WAKE_CYC = 8
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reset_soft_sleep_bit_pin_n_i,
	input wire pmra_pkg::pmra_req_t host_req_i,
	input wire pmra_pkg::pmra_rsp_t host_rsp_o,
	input wire logic host_ready_o,
	input wire logic osc_en_o,
	input wire logic osc_buf_en_o,
	input wire logic antenna1_drive_o,
	input wire logic antenna2_drive_o,
	input wire logic [3:0] cmd_code_o,
	input wire logic cmd_done_i
);
	import pmra_pkg::*;
	logic [1:0] osc_q_r;
	// oscillator up two cycles, so recovery from pin power-down is over
	always_ff @(posedge clk_i) begin
		osc_q_r <= reset_i ? 2'h0 : {osc_q_r[0], osc_en_o};
	end
	wire logic up = host_ready_o && (&osc_q_r) && reset_soft_sleep_bit_pin_n_i;
	wire logic take_rd = up && host_req_i.rd && !host_req_i.wr;
	wire logic take_cmd = up && host_req_i.wr && host_req_i.addr == A_CMD;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	a_read_answer_two: assert property (take_rd |-> ##2 host_rsp_o.valid)
		else $error("read not answered");
	a_answer_has_cause: assert property (host_rsp_o.valid |-> $past(host_req_i.rd, 2))
		else $error("answer without read");
	a_sleep_entry: assert property (take_cmd && host_req_i.wdata[4] |=> !osc_buf_en_o)
		else $error("sleep not entered");
	a_wake_release: assert property (
		take_cmd && !host_req_i.wdata[4] && !osc_buf_en_o |=> osc_buf_en_o)
		else $error("oscillator buffer not restarted");
	a_antenna_off: assert property (
		up && host_req_i.wr && host_req_i.addr == A_TX_CTL && host_req_i.wdata[1:0] != 2'h3
		|-> ##[1:2] !antenna1_drive_o && !antenna2_drive_o)
		else $error("antenna left on");
	a_antenna_pair: assert property (antenna1_drive_o == antenna2_drive_o)
		else $error("antenna drivers differ");
	a_startup_hold: assert property (
		$fell(reset_i) |-> !host_ready_o [*8] ##[1:4] host_ready_o)
		else $error("start-up delay wrong");
	a_done_idle: assert property (
		cmd_done_i && up && !take_cmd |-> ##[1:2] cmd_code_o == CMD_IDLE)
		else $error("command field not idle");
	a_cmd_follows: assert property (
		take_cmd |-> ##2 cmd_code_o == $past(host_req_i.wdata[3:0], 2))
		else $error("command field not written");
	a_hard_pd_osc: assert property (
		!reset_soft_sleep_bit_pin_n_i [*7] |-> !osc_en_o && !osc_buf_en_o)
		else $error("oscillator on in power-down");
	a_spike_kept: assert property (
		osc_en_o && $fell(reset_soft_sleep_bit_pin_n_i) ##1 reset_soft_sleep_bit_pin_n_i
		|-> osc_en_o [*4])
		else $error("spike caused power-down");
	c_read: cover property (take_rd ##2 host_rsp_o.valid);
	c_wake: cover property ($rose(osc_buf_en_o));
	c_hard_pd: cover property (!osc_en_o && !reset_soft_sleep_bit_pin_n_i);
endmodule : pmra_top_monitor
bind pmra_top pmra_top_monitor #(.STARTUP_CYC(STARTUP_CYC), .WAKE_CYC(WAKE_CYC)) mon_u (
	.clk_i(clk_i), .reset_i(reset_i), .reset_soft_sleep_bit_pin_n_i(reset_soft_sleep_bit_pin_n_i),
	.host_req_i(host_req_i), .host_rsp_o(host_rsp_o), .host_ready_o(host_ready_o),
	.osc_en_o(osc_en_o), .osc_buf_en_o(osc_buf_en_o), .antenna1_drive_o(antenna1_drive_o),
	.antenna2_drive_o(antenna2_drive_o), .cmd_code_o(cmd_code_o), .cmd_done_i(cmd_done_i)
);

// ---- test/pmra_host_model.sv ----
// host side model: one-cycle register requests, bounded waits for answers
// drives requests 2 ns after a rising edge, once ready is high or after 40 cycles without it
`timescale 1ns/1ns
module pmra_host_model (
	input wire logic clk_i,
	input wire logic host_ready_i,
	input wire pmra_pkg::pmra_rsp_t host_rsp_i,
	output pmra_pkg::pmra_req_t host_req_o
);
	import pmra_pkg::*;
	initial host_req_o = '0;
	task automatic wait_ready(output bit ok);
		ok = 0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clk_i);
			#2;
			ok = (host_ready_i === 1'b1);
		end
	endtask : wait_ready
	task automatic wr(input logic [5:0] a, input logic [7:0] v, output bit ok);
		wait_ready(ok);
		host_req_o = {1'b0, 1'b1, a, v};
		@(posedge clk_i);
		#2;
		host_req_o = '0;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [7:0] v, output bit ok);
		wait_ready(ok);
		host_req_o = {1'b1, 1'b0, a, 8'h00};
		@(posedge clk_i);
		#2;
		host_req_o = '0;
		ok = 0;
		v = 8'h00;
		for (int i = 0; i < 3 && !ok; i++) begin
			@(posedge clk_i);
			#2;
			ok = (host_rsp_i.valid === 1'b1);
			v = host_rsp_i.data;
		end
	endtask : rd
	// read address 0 until it answers before any other access
	// no uart link here, so no lead byte goes ahead of the poll
	task automatic poll0(output bit ok);
		logic [7:0] v;
		ok = 0;
		for (int i = 0; i < 20 && !ok; i++) rd(A_RSVD0, v, ok);
	endtask : poll0
endmodule : pmra_host_model

// ---- test/test_power_mode_and_register_access.sv ----
// bench: register map, sleep entry and exit, reset pin power-down
// host model issues all register traffic; start-up and wake counts shortened
`timescale 1ns/1ns
module test_power_mode_and_register_access;
	import pmra_pkg::*;
	localparam int WAKE = 8;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic pin_n = 1'b1;
	logic done = 1'b0;
	logic [6:0] ev_c = 7'h00;
	logic [6:0] ev_m = 7'h00;
	logic [7:0] err_f = 8'h00;
	logic [5:0] st1 = 6'h00;
	logic [3:0] st2 = 4'h0;
	logic [5:0] mst = 6'h00;
	pmra_req_t req;
	pmra_rsp_t rsp;
	logic ready, osc, obuf, an1, an2;
	logic [3:0] cmd;
	logic tst, tsp;
	logic [7:0] rm [int];
	logic [7:0] fq [$];
	logic [7:0] d;
	bit ok;
	int bad_count = 0;
	int n_compared = 0;
	int n, t0;
	always #25 clk_i = ~clk_i;
	pmra_top #(.STARTUP_CYC(8), .WAKE_CYC(WAKE), .DEPTH(64)) dut_u (
		.clk_i(clk_i), .reset_i(reset_i), .reset_soft_sleep_bit_pin_n_i(pin_n),
		.host_req_i(req), .host_rsp_o(rsp), .host_ready_o(ready), .osc_en_o(osc),
		.osc_buf_en_o(obuf), .antenna1_drive_o(an1), .antenna2_drive_o(an2),
		.cmd_code_o(cmd), .timer_start_o(tst), .timer_stop_o(tsp), .cmd_done_i(done),
		.comm_irq_event_i(ev_c), .misc_irq_event_i(ev_m), .error_flags_i(err_f),
		.status1_i(st1), .status2_i(st2), .misc_status_i(mst)
	);
	pmra_host_model host_u (.clk_i(clk_i), .host_ready_i(ready), .host_rsp_i(rsp),
		.host_req_o(req));
	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
		host_u.rd(a, d, ok);
		chk("answer", {7'h0, ok}, 8'h01);
		if (!ok) end_of_test;
		chk($sformatf("reg %h", a), d, exp);
	endtask : rdchk
	task automatic wreg(input logic [5:0] a, input logic [7:0] v);
		host_u.wr(a, v, ok);
		if (!ok) begin
			chk("ready", 8'h00, 8'h01);
			end_of_test;
		end
	endtask : wreg
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#2;
	endtask : tick
	initial begin
		n = $urandom(18);
		err_f = 8'($urandom);
		st1 = 6'($urandom);
		st2 = 4'($urandom);
		mst = 6'($urandom);
		tick(5);
		reset_i = 1'b0;
		host_u.poll0(ok);
		chk("ready", {7'h0, ok}, 8'h01);
		if (!ok) end_of_test;
		rm[2] = RST_IRQ_EN;
		rm[3] = RST_IRQ_EN;
		rm[11] = {2'b00, RST_WATER};
		foreach (rm[a]) rdchk(a[5:0], rm[a]);
		foreach (rm[a]) begin
			n = $urandom;
			if (a == 11) n[7:6] = 2'b00;
			wreg(a[5:0], n[7:0]);
			rm[a] = n[7:0];
		end
		foreach (rm[a]) rdchk(a[5:0], rm[a]);
		wreg(A_RSVD0, 8'h00);
		wreg(A_ERROR, 8'hff);
		wreg(6'h21, 8'h5a);
		wreg(A_MISC_CTL, 8'hc0);
		chk("timers", {6'h0, tst, tsp}, 8'h03);
		tick(1);
		chk("timers", {6'h0, tst, tsp}, 8'h00);
		rdchk(A_RSVD0, 8'h00);
		rdchk(6'h21, 8'h00);
		rdchk(A_ERROR, err_f);
		rdchk(A_MISC_CTL, {2'b00, mst});
		rdchk(A_STAT2, {RST_STAT2_CTL, st2});
		wreg(A_STAT2, 8'hc0);
		rdchk(A_STAT2, {4'hc, st2});
		for (int i = 4; i < 6; i++) begin
			n = $urandom;
			wreg(i[5:0], 8'h7f);
			ev_c = (i == 4) ? n[6:0] : 7'h00;
			ev_m = (i == 5) ? n[6:0] : 7'h00;
			tick(1);
			ev_c = 7'h00;
			ev_m = 7'h00;
			rdchk(i[5:0], {1'b0, n[6:0]});
			wreg(i[5:0], 8'h81);
			rdchk(i[5:0], {1'b0, n[6:0] | 7'h01});
		end
		n = 3 + $urandom_range(4);
		repeat (n) begin
			fq.push_back(8'($urandom));
			wreg(A_FIFO_DATA, fq[$]);
		end
		rdchk(A_FIFO_LVL, 8'(n));
		t0 = int'(rm[11]);
		rdchk(A_STAT1, {st1, (FIFO_DEPTH - n <= t0), (n <= t0)});
		while (fq.size() > 0) rdchk(A_FIFO_DATA, fq.pop_front());
		wreg(A_FIFO_DATA, 8'h3c);
		wreg(A_FIFO_LVL, 8'h80);
		rdchk(A_FIFO_LVL, 8'h00);
		wreg(A_TX_CTL, 8'h03);
		tick(2);
		chk("antennas", {6'h0, an1, an2}, 8'h03);
		wreg(A_CMD, 8'h13);
		tick(2);
		chk("sleep outputs", {5'h0, obuf, an1, an2}, 8'h00);
		chk("cmd", {4'h0, cmd}, 8'h03);
		rdchk(A_CMD, 8'h13);
		rdchk(A_COMM_EN, rm[2]);
		rdchk(A_WATER, rm[11]);
		wreg(A_CMD, 8'h03);
		rdchk(A_CMD, 8'h13);
		wreg(A_CMD, 8'h13);
		wreg(A_CMD, 8'h03);
		t0 = int'($time / 50);
		d = 8'h10;
		for (int i = 0; i < 40 && d[4]; i++) host_u.rd(A_CMD, d, ok);
		n = int'($time / 50) - t0;
		chk("wake", {7'h0, n >= WAKE && n <= WAKE + 24}, 8'h01);
		rdchk(A_CMD, 8'h03);
		done = 1'b1;
		tick(1);
		done = 1'b0;
		tick(2);
		chk("cmd", {4'h0, cmd}, 8'h00);
		rdchk(A_CMD, 8'h00);
		wreg(A_TX_CTL, 8'h02);
		tick(2);
		chk("antennas", {6'h0, an1, an2}, 8'h00);
		pin_n = 1'b0;
		tick(1);
		pin_n = 1'b1;
		tick(6);
		chk("spike", {6'h0, osc, ready}, 8'h03);
		pin_n = 1'b0;
		tick(8);
		chk("hard pd", {4'h0, osc, obuf, ready, an1}, 8'h02);
		pin_n = 1'b1;
		host_u.poll0(ok);
		chk("ready", {7'h0, ok}, 8'h01);
		if (!ok) end_of_test;
		rdchk(A_COMM_EN, RST_IRQ_EN);
		end_of_test;
	end
	initial begin
		#3000000;
		bad_count++;
		end_of_test;
	end
endmodule : test_power_mode_and_register_access
